// ==== cmd_host.sv ====
// Host model that issues one command request at a time to the limit bank
module cmd_host
    import limit_bank_pkg::*;
(
    input wire logic clock,
    output cmd_req_t req,
    input wire cmd_rsp_t rsp
);
    timeunit 1ns;
    timeprecision 100ps;

    // ==========================================================
    // Request cycle
    initial req = '0;

    // Word size for level entries, byte size for action bytes
    task automatic cmd(input logic wr, input logic wd, input logic [7:0] code, input logic [15:0] data,
                       output cmd_rsp_t r);
        @(posedge clock);
        req <= '{valid: 1'b1, write: wr, is_word: wd, code: code, data: data};
        @(posedge clock);
        // Released lines show inverted data, so a stale value cannot pass for a held one
        req <= '{valid: 1'b0, write: ~wr, is_word: ~wd, code: ~code, data: ~data};
        #1 r = rsp;
    endtask
endmodule

// ==== fault_limit_command_bank.sv ====
// Command-addressed limit and fault-action bank for a two-channel power controller
// How it works
// - Unpaged switching rate word at 0x33, 0xFABC
// - Unpaged start threshold 0x35; conversion starts at or above
// - Unpaged stop threshold 0x36; stop at or below
// - Paged sense gain 0x38, default 0xBB9A
// - Paged overvolt fault level and action byte
// - Paged overvolt warning level 0x42, flagged above
// - Paged undervolt warning level 0x43, flagged below
// - Paged undervolt fault level and action byte
// - Paged overcurrent fault level, action resets 0x00
// - Paged overcurrent warning 0x4A, flagged above
// - Paged overtemp fault level and action byte
// - Paged overtemp warning 0x51, flagged above
// - Paged undertemp fault level and action byte
// - Unpaged input overvolt level, paged action byte
// - Unpaged input undervolt warning 0x58, below
// - Unpaged input overcurrent warning 0x5D, above
// - Output good set at or above 0x5E
// - Output good cleared at or below 0x5F
// - Output voltage words unsigned, format byte reads 0x14
// - Page byte 0x00 selects channel copy
// - Unsupported codes raise communication fault
module fault_limit_command_bank
    import limit_bank_pkg::*;
#(
    parameter int channels = 2
) (
    input wire logic clock,
    input wire logic resetn,
    input wire cmd_req_t req,
    input wire chan_meas_t [1:0] meas,
    input wire input_meas_t in_meas,
    output cmd_rsp_t rsp,
    output logic communication_fault,
    output logic [15:0] switching_rate_setpoint,
    output logic [15:0] current_sense_gain [2],
    output logic [7:0] fault_action [2][6],
    output input_flags_t in_flags,
    output chan_flags_t [1:0] ch_flags
);

    // ==========================================================
    // Assertion clock and reset
    default clocking @(posedge clock);
    endclocking
    default disable iff (!resetn);

    // ==========================================================
    // Slot decode for paged entries
    function automatic logic [4:0] paged_slot(input logic [7:0] code);
        case (code)
            cmd_current_sense_gain: paged_slot = 5'h00;
            cmd_out_overvolt_fault_level: paged_slot = 5'h01;
            cmd_out_overvolt_fault_action: paged_slot = 5'h02;
            cmd_out_overvolt_warn_level: paged_slot = 5'h03;
            cmd_out_undervolt_warn_level: paged_slot = 5'h04;
            cmd_out_undervolt_fault_level: paged_slot = 5'h05;
            cmd_out_undervolt_fault_action: paged_slot = 5'h06;
            cmd_out_overcurrent_fault_level: paged_slot = 5'h07;
            cmd_out_overcurrent_fault_action: paged_slot = 5'h08;
            cmd_out_overcurrent_warn_level: paged_slot = 5'h09;
            cmd_overtemp_fault_level: paged_slot = 5'h0a;
            cmd_overtemp_fault_action: paged_slot = 5'h0b;
            cmd_overtemp_warn_level: paged_slot = 5'h0c;
            cmd_undertemp_fault_level: paged_slot = 5'h0d;
            cmd_undertemp_fault_action: paged_slot = 5'h0e;
            cmd_input_overvolt_fault_action: paged_slot = 5'h0f;
            cmd_output_good_assert_level: paged_slot = 5'h10;
            cmd_output_good_release_level: paged_slot = 5'h11;
            default: paged_slot = slot_none;
        endcase
    endfunction

    function automatic logic is_byte_slot(input logic [4:0] s);
        is_byte_slot = (s == 5'h02) || (s == 5'h06) || (s == 5'h08) || (s == 5'h0b)
            || (s == 5'h0e) || (s == 5'h0f);
    endfunction

    function automatic logic [15:0] paged_default(input logic [4:0] s);
        case (s)
            5'h00: paged_default = rst_current_sense_gain;
            5'h01: paged_default = rst_out_overvolt_fault_level;
            5'h02: paged_default = {8'h00, rst_out_overvolt_fault_action};
            5'h03: paged_default = rst_out_overvolt_warn_level;
            5'h04: paged_default = rst_out_undervolt_warn_level;
            5'h05: paged_default = rst_out_undervolt_fault_level;
            5'h06: paged_default = {8'h00, rst_out_undervolt_fault_action};
            5'h07: paged_default = rst_out_overcurrent_fault_level;
            5'h08: paged_default = {8'h00, rst_out_overcurrent_fault_action};
            5'h09: paged_default = rst_out_overcurrent_warn_level;
            5'h0a: paged_default = rst_overtemp_fault_level;
            5'h0b: paged_default = {8'h00, rst_overtemp_fault_action};
            5'h0c: paged_default = rst_overtemp_warn_level;
            5'h0d: paged_default = rst_undertemp_fault_level;
            5'h0e: paged_default = {8'h00, rst_undertemp_fault_action};
            5'h0f: paged_default = {8'h00, rst_input_overvolt_fault_action};
            5'h10: paged_default = rst_output_good_assert_level;
            5'h11: paged_default = rst_output_good_release_level;
            default: paged_default = 16'h0000;
        endcase
    endfunction

    // Signed compare for five-bit-exponent linear words of equal exponent
    function automatic logic lin_gt(input logic [15:0] a, input logic [15:0] b);
        lin_gt = $signed(a[10:0]) > $signed(b[10:0]);
    endfunction

    // ==========================================================
    // Storage
    localparam int nslots = num_paged + 1;
    logic [15:0] paged_reg [2][nslots];
    logic [7:0] page_reg;
    logic [15:0] input_start_threshold_reg;
    logic [15:0] input_stop_threshold_reg;
    logic [15:0] input_overvolt_fault_level_reg;
    logic [15:0] input_undervolt_warn_level_reg;
    logic [15:0] input_overcurrent_warn_level_reg;
    logic [15:0] switching_rate_reg;

    logic [4:0] slot;
    logic chan;
    logic unpaged_hit;
    logic [15:0] unpaged_rd;
    logic write_ok;
    assign slot = paged_slot(req.code);
    assign chan = page_reg[0];

    always_comb begin
        unpaged_hit = 1'b1;
        unpaged_rd = 16'h0000;
        case (req.code)
            cmd_page: unpaged_rd = {8'h00, page_reg};
            cmd_output_format_byte: unpaged_rd = {8'h00, output_format_value};
            cmd_switching_rate_setpoint: unpaged_rd = switching_rate_reg;
            cmd_input_start_threshold: unpaged_rd = input_start_threshold_reg;
            cmd_input_stop_threshold: unpaged_rd = input_stop_threshold_reg;
            cmd_input_overvolt_fault_level: unpaged_rd = input_overvolt_fault_level_reg;
            cmd_input_undervolt_warn_level: unpaged_rd = input_undervolt_warn_level_reg;
            cmd_input_overcurrent_warn_level: unpaged_rd = input_overcurrent_warn_level_reg;
            default: unpaged_hit = 1'b0;
        endcase
    end

    // Format byte is read-only; a page beyond the channels is rejected
    assign write_ok = req.valid && req.write
        && !(req.code == cmd_output_format_byte)
        && !(req.code == cmd_page && req.data[7:0] >= 8'(channels))
        && (unpaged_hit || slot != slot_none);

    // ==========================================================
    // Page selector
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            page_reg <= rst_page;
        end else if (write_ok && req.code == cmd_page) begin
            page_reg <= req.data[7:0];
        end
    end

    // ==========================================================
    // Unpaged words
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            switching_rate_reg <= rst_switching_rate_setpoint;
            input_start_threshold_reg <= rst_input_start_threshold;
            input_stop_threshold_reg <= rst_input_stop_threshold;
            input_overvolt_fault_level_reg <= rst_input_overvolt_fault_level;
            input_undervolt_warn_level_reg <= rst_input_undervolt_warn_level;
            input_overcurrent_warn_level_reg <= rst_input_overcurrent_warn_level;
        end else if (write_ok) begin
            case (req.code)
                cmd_switching_rate_setpoint: switching_rate_reg <= req.data;
                cmd_input_start_threshold: input_start_threshold_reg <= req.data;
                cmd_input_stop_threshold: input_stop_threshold_reg <= req.data;
                cmd_input_overvolt_fault_level: input_overvolt_fault_level_reg <= req.data;
                cmd_input_undervolt_warn_level: input_undervolt_warn_level_reg <= req.data;
                cmd_input_overcurrent_warn_level: input_overcurrent_warn_level_reg <= req.data;
                default: ;
            endcase
        end
    end

    // ==========================================================
    // Paged copies, one per channel
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            for (int c = 0; c < 2; c++) begin
                for (int s = 0; s < nslots; s++) begin
                    paged_reg[c][s] <= paged_default(5'(s));
                end
            end
        end else if (write_ok && slot != slot_none) begin
            // Byte entries keep only the low byte
            paged_reg[chan][slot] <= is_byte_slot(slot) ? {8'h00, req.data[7:0]} : req.data;
        end
    end

    // ==========================================================
    // Response, one cycle after the request
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            rsp <= '0;
            communication_fault <= 1'b0;
        end else begin
            rsp.valid <= req.valid;
            rsp.fault <= req.valid && !unpaged_hit && slot == slot_none;
            communication_fault <= req.valid && !(unpaged_hit || slot != slot_none)
                || (req.valid && req.write && !write_ok);
            if (unpaged_hit) begin
                rsp.data <= unpaged_rd;
            end else if (slot != slot_none) begin
                rsp.data <= paged_reg[chan][slot];
            end else begin
                rsp.data <= 16'h0000;
            end
        end
    end

    // ==========================================================
    // Configuration outputs
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            switching_rate_setpoint <= rst_switching_rate_setpoint;
            for (int c = 0; c < 2; c++) begin
                current_sense_gain[c] <= rst_current_sense_gain;
                for (int k = 0; k < 6; k++) begin
                    fault_action[c][k] <= 8'h00;
                end
            end
        end else begin
            switching_rate_setpoint <= switching_rate_reg;
            for (int c = 0; c < 2; c++) begin
                current_sense_gain[c] <= paged_reg[c][0];
                fault_action[c][0] <= paged_reg[c][2][7:0];
                fault_action[c][1] <= paged_reg[c][6][7:0];
                fault_action[c][2] <= paged_reg[c][8][7:0];
                fault_action[c][3] <= paged_reg[c][11][7:0];
                fault_action[c][4] <= paged_reg[c][14][7:0];
                fault_action[c][5] <= paged_reg[c][15][7:0];
            end
        end
    end

    // ==========================================================
    // Input-side comparisons; start/stop hysteresis
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            in_flags <= '0;
        end else begin
            if (!lin_gt(input_start_threshold_reg, in_meas.vin)) begin
                in_flags.conv_enable <= 1'b1;
            end else if (!lin_gt(in_meas.vin, input_stop_threshold_reg)) begin
                in_flags.conv_enable <= 1'b0;
            end
            in_flags.vin_ov_fault <= lin_gt(in_meas.vin, input_overvolt_fault_level_reg);
            in_flags.vin_uv_warn <= lin_gt(input_undervolt_warn_level_reg, in_meas.vin);
            in_flags.iin_oc_warn <= lin_gt(in_meas.iin, input_overcurrent_warn_level_reg);
        end
    end

    // ==========================================================
    // Per-channel comparisons; voltages are compared as whole unsigned 16-bit words
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            ch_flags <= '0;
        end else begin
            for (int c = 0; c < 2; c++) begin
                ch_flags[c].ov_fault <= meas[c].vout > paged_reg[c][1];
                ch_flags[c].ov_warn <= meas[c].vout > paged_reg[c][3];
                ch_flags[c].uv_warn <= meas[c].vout < paged_reg[c][4];
                ch_flags[c].uv_fault <= meas[c].vout < paged_reg[c][5];
                ch_flags[c].oc_fault <= lin_gt(meas[c].iout, paged_reg[c][7]);
                ch_flags[c].oc_warn <= lin_gt(meas[c].iout, paged_reg[c][9]);
                ch_flags[c].ot_fault <= lin_gt(meas[c].temp, paged_reg[c][10]);
                ch_flags[c].ot_warn <= lin_gt(meas[c].temp, paged_reg[c][12]);
                ch_flags[c].ut_fault <= lin_gt(paged_reg[c][13], meas[c].temp);
                if (meas[c].vout >= paged_reg[c][16]) begin
                    ch_flags[c].output_good <= 1'b1;
                end else if (meas[c].vout <= paged_reg[c][17]) begin
                    ch_flags[c].output_good <= 1'b0;
                end
            end
        end
    end

    // ==========================================================
    // Checks
    a_page_write: assert property (
        write_ok && req.code == cmd_page
        |=> page_reg == $past(req.data[7:0]))
        else $error("page not updated");
    a_bad_code_fault: assert property (
        req.valid && !unpaged_hit && slot == slot_none
        |=> rsp.fault && communication_fault)
        else $error("unsupported code not faulted");
    a_format_byte: assert property (
        req.valid && req.code == cmd_output_format_byte
        |=> rsp.data == 16'h0014)
        else $error("format byte wrong");
    a_rate_write: assert property (
        write_ok && req.code == cmd_switching_rate_setpoint
        |=> ##1 switching_rate_setpoint == $past(req.data, 2))
        else $error("rate not written");
    a_good_set: assert property (
        meas[0].vout >= paged_reg[0][16]
        |=> ch_flags[0].output_good)
        else $error("output good not set");
    a_good_clear: assert property (
        meas[0].vout <= paged_reg[0][17] && meas[0].vout < paged_reg[0][16]
        |=> !ch_flags[0].output_good)
        else $error("output good not cleared");
    a_ov_warn: assert property (
        meas[1].vout > paged_reg[1][3]
        |=> ch_flags[1].ov_warn)
        else $error("overvolt warning missed");
    a_uv_warn: assert property (
        meas[0].vout < paged_reg[0][4]
        |=> ch_flags[0].uv_warn)
        else $error("undervolt warning missed");
    a_start_conv: assert property (
        lin_gt(input_start_threshold_reg, in_meas.vin) && !in_flags.conv_enable
        |=> !in_flags.conv_enable)
        else $error("started below threshold");
    a_stop_conv: assert property (
        !lin_gt(in_meas.vin, input_stop_threshold_reg) && lin_gt(input_start_threshold_reg, in_meas.vin)
        |=> !in_flags.conv_enable)
        else $error("conversion not stopped");
    a_gain_copy: assert property (
        current_sense_gain[1] == $past(paged_reg[1][0]))
        else $error("sense gain not copied");
    a_ov_fault: assert property (
        meas[1].vout > paged_reg[1][1]
        |=> ch_flags[1].ov_fault)
        else $error("overvolt fault missed");
    a_uv_fault: assert property (
        meas[1].vout < paged_reg[1][5]
        |=> ch_flags[1].uv_fault)
        else $error("undervolt fault missed");
    a_oc_fault: assert property (
        lin_gt(meas[1].iout, paged_reg[1][7])
        |=> ch_flags[1].oc_fault)
        else $error("overcurrent fault missed");
    a_oc_warn: assert property (
        lin_gt(meas[1].iout, paged_reg[1][9])
        |=> ch_flags[1].oc_warn)
        else $error("overcurrent warning missed");
    a_ot_fault: assert property (
        lin_gt(meas[1].temp, paged_reg[1][10])
        |=> ch_flags[1].ot_fault)
        else $error("overtemp fault missed");
    a_ot_warn: assert property (
        lin_gt(meas[1].temp, paged_reg[1][12])
        |=> ch_flags[1].ot_warn)
        else $error("overtemp warning missed");
    a_ut_fault: assert property (
        lin_gt(paged_reg[1][13], meas[1].temp)
        |=> ch_flags[1].ut_fault)
        else $error("undertemp fault missed");
    a_vin_ov: assert property (
        lin_gt(in_meas.vin, input_overvolt_fault_level_reg)
        |=> in_flags.vin_ov_fault)
        else $error("input overvolt fault missed");
    a_vin_uv: assert property (
        lin_gt(input_undervolt_warn_level_reg, in_meas.vin)
        |=> in_flags.vin_uv_warn)
        else $error("input undervolt warning missed");
    a_iin_oc: assert property (
        lin_gt(in_meas.iin, input_overcurrent_warn_level_reg)
        |=> in_flags.iin_oc_warn)
        else $error("input overcurrent warning missed");

endmodule

// ==== limit_bank_pkg.sv ====
// Package: command codes, reset values and carrier types for the limit command bank
package limit_bank_pkg;

    // ==========================================================
    // Command codes
    localparam logic [7:0] cmd_page = 8'h00;
    localparam logic [7:0] cmd_output_format_byte = 8'h20;
    localparam logic [7:0] cmd_switching_rate_setpoint = 8'h33;
    localparam logic [7:0] cmd_input_start_threshold = 8'h35;
    localparam logic [7:0] cmd_input_stop_threshold = 8'h36;
    localparam logic [7:0] cmd_current_sense_gain = 8'h38;
    localparam logic [7:0] cmd_out_overvolt_fault_level = 8'h40;
    localparam logic [7:0] cmd_out_overvolt_fault_action = 8'h41;
    localparam logic [7:0] cmd_out_overvolt_warn_level = 8'h42;
    localparam logic [7:0] cmd_out_undervolt_warn_level = 8'h43;
    localparam logic [7:0] cmd_out_undervolt_fault_level = 8'h44;
    localparam logic [7:0] cmd_out_undervolt_fault_action = 8'h45;
    localparam logic [7:0] cmd_out_overcurrent_fault_level = 8'h46;
    localparam logic [7:0] cmd_out_overcurrent_fault_action = 8'h47;
    localparam logic [7:0] cmd_out_overcurrent_warn_level = 8'h4a;
    localparam logic [7:0] cmd_overtemp_fault_level = 8'h4f;
    localparam logic [7:0] cmd_overtemp_fault_action = 8'h50;
    localparam logic [7:0] cmd_overtemp_warn_level = 8'h51;
    localparam logic [7:0] cmd_undertemp_fault_level = 8'h53;
    localparam logic [7:0] cmd_undertemp_fault_action = 8'h54;
    localparam logic [7:0] cmd_input_overvolt_fault_level = 8'h55;
    localparam logic [7:0] cmd_input_overvolt_fault_action = 8'h56;
    localparam logic [7:0] cmd_input_undervolt_warn_level = 8'h58;
    localparam logic [7:0] cmd_input_overcurrent_warn_level = 8'h5d;
    localparam logic [7:0] cmd_output_good_assert_level = 8'h5e;
    localparam logic [7:0] cmd_output_good_release_level = 8'h5f;

    // ==========================================================
    // Reset values
    localparam logic [7:0] rst_page = 8'h00;
    localparam logic [7:0] output_format_value = 8'h14;
    localparam logic [15:0] rst_switching_rate_setpoint = 16'hfabc;
    localparam logic [15:0] rst_input_start_threshold = 16'hcb40;
    localparam logic [15:0] rst_input_stop_threshold = 16'hcb00;
    localparam logic [15:0] rst_current_sense_gain = 16'hbb9a;
    localparam logic [15:0] rst_out_overvolt_fault_level = 16'h119a;
    localparam logic [7:0] rst_out_overvolt_fault_action = 8'hb8;
    localparam logic [15:0] rst_out_overvolt_warn_level = 16'h1133;
    localparam logic [15:0] rst_out_undervolt_warn_level = 16'h0ecd;
    localparam logic [15:0] rst_out_undervolt_fault_level = 16'h0e66;
    localparam logic [7:0] rst_out_undervolt_fault_action = 8'hb8;
    localparam logic [15:0] rst_out_overcurrent_fault_level = 16'hdbb8;
    localparam logic [7:0] rst_out_overcurrent_fault_action = 8'h00;
    localparam logic [15:0] rst_out_overcurrent_warn_level = 16'hda80;
    localparam logic [15:0] rst_overtemp_fault_level = 16'heb20;
    localparam logic [7:0] rst_overtemp_fault_action = 8'hb8;
    localparam logic [15:0] rst_overtemp_warn_level = 16'heaa8;
    localparam logic [15:0] rst_undertemp_fault_level = 16'he580;
    localparam logic [7:0] rst_undertemp_fault_action = 8'hb8;
    localparam logic [15:0] rst_input_overvolt_fault_level = 16'hd3e0;
    localparam logic [7:0] rst_input_overvolt_fault_action = 8'h80;
    localparam logic [15:0] rst_input_undervolt_warn_level = 16'hcb26;
    localparam logic [15:0] rst_input_overcurrent_warn_level = 16'hd280;
    localparam logic [15:0] rst_output_good_assert_level = 16'h0ee1;
    localparam logic [15:0] rst_output_good_release_level = 16'h0eb8;

    // ==========================================================
    // Paged slot numbering inside the per-channel arrays
    localparam int num_paged = 17;
    localparam logic [4:0] slot_none = 5'h1f;

    // ==========================================================
    // Carriers
    typedef struct packed {
        logic valid;
        logic write;
        logic is_word;
        logic [7:0] code;
        logic [15:0] data;
    } cmd_req_t;

    typedef struct packed {
        logic valid;
        logic fault;
        logic [15:0] data;
    } cmd_rsp_t;

    typedef struct packed {
        logic [15:0] vout;
        logic [15:0] iout;
        logic [15:0] temp;
    } chan_meas_t;

    typedef struct packed {
        logic [15:0] vin;
        logic [15:0] iin;
    } input_meas_t;

    typedef struct packed {
        logic conv_enable;
        logic vin_ov_fault;
        logic vin_uv_warn;
        logic iin_oc_warn;
    } input_flags_t;

    typedef struct packed {
        logic ov_fault;
        logic ov_warn;
        logic uv_warn;
        logic uv_fault;
        logic oc_fault;
        logic oc_warn;
        logic ot_fault;
        logic ot_warn;
        logic ut_fault;
        logic output_good;
    } chan_flags_t;

endpackage

// ==== testbench.sv ====
// Testbench for the limit bank: defaults, paging, refusals and limit flags
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    import limit_bank_pkg::*;

    // ==========================================================
    // Signals
    logic clock = 1'b0;
    logic resetn = 1'b0;
    cmd_req_t req;
    cmd_rsp_t rsp;
    cmd_rsp_t r;
    chan_meas_t [1:0] meas = {2{16'h1000, 16'hd000, 16'he000}};
    input_meas_t in_meas = {16'hcb00, 16'hd000};
    logic communication_fault;
    logic [15:0] switching_rate_setpoint;
    logic [15:0] current_sense_gain [2];
    logic [7:0] fault_action [2][6];
    input_flags_t in_flags;
    chan_flags_t [1:0] ch_flags;
    int err_count = 0;
    int n_compared = 0;
    // Code in the top byte, default below
    logic [23:0] tab [24] = '{24'h33_fabc, 24'h35_cb40, 24'h36_cb00, 24'h38_bb9a, 24'h40_119a, 24'h41_00b8,
        24'h42_1133, 24'h43_0ecd, 24'h44_0e66, 24'h45_00b8, 24'h46_dbb8, 24'h47_0000, 24'h4a_da80,
        24'h4f_eb20, 24'h50_00b8, 24'h51_eaa8, 24'h53_e580, 24'h54_00b8, 24'h55_d3e0, 24'h56_0080,
        24'h58_cb26, 24'h5d_d280, 24'h5e_0ee1, 24'h5f_0eb8};

    always #2.5 clock = ~clock;

    fault_limit_command_bank i_dut (.clock(clock), .resetn(resetn), .req(req), .meas(meas), .in_meas(in_meas),
        .rsp(rsp), .communication_fault(communication_fault), .switching_rate_setpoint(switching_rate_setpoint),
        .current_sense_gain(current_sense_gain), .fault_action(fault_action), .in_flags(in_flags),
        .ch_flags(ch_flags));
    cmd_host i_host (.clock(clock), .req(req), .rsp(rsp));

    // ==========================================================
    // Shared tasks
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic summarize();
        if (err_count == 0 && n_compared > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic acc(input logic wr, input logic wd, input logic [7:0] c, input logic [15:0] d);
        i_host.cmd(wr, wd, c, d, r);
    endtask

    // Written entries hold the inverted default; bytes keep the low byte only
    task automatic read_bank(input logic pg, input logic written);
        logic [15:0] e;
        logic [7:0] c;
        for (int i = 0; i < 24; i++) begin
            c = tab[i][23:16];
            e = tab[i][15:0];
            if (written && (pg || c inside {8'h33, 8'h35, 8'h36, 8'h55, 8'h58, 8'h5d}))
                e = e ^ (|e[15:8] ? 16'hffff : 16'h00ff);
            acc(1'b0, |tab[i][15:8], c, 16'h0000);
            check(r.data, e);
        end
    endtask

    // Flags order: good, ov warn, uv warn, conversion, input uv warn
    task automatic level(input logic [15:0] vo, input logic [15:0] vi, input logic [4:0] e);
        @(posedge clock);
        meas[0].vout <= vo;
        in_meas.vin <= vi;
        repeat (3) @(posedge clock);
        #1 check({11'h000, ch_flags[0].output_good, ch_flags[0].ov_warn, ch_flags[0].uv_warn,
            in_flags.conv_enable, in_flags.vin_uv_warn}, {11'h000, e});
    endtask

    // Channel 1 and input flags against the default limits
    task automatic fault_flags(input chan_meas_t m, input input_meas_t v, input logic [9:0] ec,
                               input logic [3:0] ei);
        @(posedge clock);
        meas[1] <= m;
        in_meas <= v;
        repeat (3) @(posedge clock);
        #1 check({6'h00, ch_flags[1]}, {6'h00, ec});
        check({12'h000, in_flags}, {12'h000, ei});
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        repeat (8) @(posedge clock);
        resetn <= 1'b1;
        read_bank(1'b0, 1'b0);
        check(switching_rate_setpoint, 16'hfabc);
        check({8'h00, fault_action[1][2]}, 16'h0000);
        level(16'h1000, 16'hcb00, 5'b10001);
        level(16'h0eb8, 16'hcb41, 5'b00110);
        level(16'h0ec0, 16'hcb20, 5'b00111);
        level(16'h0ee1, 16'hcb20, 5'b10011);
        level(16'h0ec0, 16'hcb00, 5'b10101);
        level(16'h1134, 16'hcb41, 5'b11010);
        fault_flags('{16'h119b, 16'hd3b9, 16'he321}, '{16'hd3e1, 16'hd281}, 10'h33d, 4'hd);
        fault_flags('{16'h0e65, 16'hd281, 16'he57f}, '{16'hcb41, 16'hd280}, 10'h0d2, 4'h8);
        acc(1'b1, 1'b0, 8'h00, 16'h0001);
        read_bank(1'b1, 1'b0);
        for (int i = 0; i < 24; i++) acc(1'b1, |tab[i][15:8], tab[i][23:16], ~tab[i][15:0]);
        read_bank(1'b1, 1'b1);
        acc(1'b1, 1'b0, 8'h00, 16'h0000);
        read_bank(1'b0, 1'b1);
        check(switching_rate_setpoint, 16'h0543);
        check(current_sense_gain[1], 16'h4465);
        check(current_sense_gain[0], 16'hbb9a);
        check({8'h00, fault_action[1][0]}, 16'h0047);
        check({8'h00, fault_action[0][0]}, 16'h00b8);
        check({8'h00, fault_action[1][5]}, 16'h007f);
        check({fault_action[1][1], fault_action[1][2]}, 16'h47ff);
        check({fault_action[1][3], fault_action[1][4]}, 16'h4747);
        // Reset in mid-run must bring back every default, paged copies too
        @(posedge clock);
        resetn <= 1'b0;
        repeat (2) @(posedge clock);
        resetn <= 1'b1;
        acc(1'b1, 1'b0, 8'h00, 16'h0001);
        read_bank(1'b1, 1'b0);
        // Refused accesses must leave no trace
        acc(1'b0, 1'b0, 8'h01, 16'h0000);
        check({14'h0000, r.valid, r.fault}, 16'h0003);
        check(r.data, 16'h0000);
        check({15'h0000, communication_fault}, 16'h0001);
        acc(1'b1, 1'b0, 8'h20, 16'h0055);
        check({15'h0000, communication_fault}, 16'h0001);
        acc(1'b0, 1'b0, 8'h20, 16'h0000);
        check(r.data, 16'h0014);
        check({15'h0000, communication_fault}, 16'h0000);
        acc(1'b1, 1'b0, 8'h00, 16'h0002);
        check({15'h0000, communication_fault}, 16'h0001);
        acc(1'b0, 1'b0, 8'h00, 16'h0000);
        check(r.data, 16'h0001);
        summarize();
    end
endmodule
